// *** common/ccp_flags_pkg.sv ***
// Package: register map, field layout, reset values and modes of the event flag block
package ccp_flags_pkg;

	// Register word offsets (byte addresses, word aligned)
	localparam logic [3:0] flags_offset     = 4'h0;
	localparam logic [3:0] mask_offset      = 4'h4;
	localparam logic [3:0] irq_stat_offset  = 4'h8;
	localparam logic [3:0] mode_offset      = 4'hC;

	// Field layout
	localparam int         unit_count       = 5;
	localparam int         unit1_bit        = 0;
	localparam int         flags_width      = 8;
	localparam int         mode_width       = 2;
	localparam int         mode_reg_width   = 10;

	// Reset values
	localparam logic [4:0] flags_reset      = 5'h00;
	localparam logic [4:0] mask_reset       = 5'h00;
	localparam logic [9:0] mode_reset       = 10'h000;
	localparam logic [31:0] unmapped_read   = 32'h00000000;

	// Unit operating modes
	typedef enum logic [1:0] {
		mode_off,
		mode_capture,
		mode_compare,
		mode_pwm
	} unit_operating_mode_t;

endpackage : ccp_flags_pkg

// *** hdl/ccp_interrupt_flag_register.sv ***
// Event flag register for five capture/compare/PWM units, Avalon-MM slave
//
// Behaviour
// - Unit N flag sits at bit N-1
// - Bits seven to five read zero, ignore writes
// - Capture mode: capture event sets unit flag
// - Compare mode: match event sets unit flag
// - PWM mode: trailing edge sets unit flag
// - Hardware never clears; software clears flags
// - All flags reset to zero on reset
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module ccp_interrupt_flag_register (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset,
	// Avalon-MM slave
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// Unit event pulses, one bit per unit
	input  wire logic [4:0]  capture_event,
	input  wire logic [4:0]  compare_event,
	input  wire logic [4:0]  pwm_trailing_edge,
	// Flags and interrupt
	output logic      [4:0]  ccp_event_flags,
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [4:0] flags_r;
	logic [4:0] flags_nxt;
	logic [4:0] mask_r;
	logic [4:0] mask_nxt;
	logic [9:0] mode_r;
	logic [4:0] hardware_set;
	logic [4:0] sw_clear;
	logic       ack_r;
	logic       wr_lo;

	// Mode field of one unit
	function automatic ccp_flags_pkg::unit_operating_mode_t unit_mode(
		input logic [9:0] modes, input int unit);
		unit_mode = ccp_flags_pkg::unit_operating_mode_t'(modes[unit*2 +: 2]);
	endfunction : unit_mode

	////////////////////////////////////////////////////////////////////////////
	// Event qualification by mode, unit N on bit N-1
	always_comb begin
		for (int i = 0; i < ccp_flags_pkg::unit_count; i++) begin
			unique case (unit_mode(mode_r, i))
				ccp_flags_pkg::mode_capture: hardware_set[i] = capture_event[i];
				ccp_flags_pkg::mode_compare: hardware_set[i] = compare_event[i];
				ccp_flags_pkg::mode_pwm:     hardware_set[i] = pwm_trailing_edge[i];
				ccp_flags_pkg::mode_off:     hardware_set[i] = 1'b0;
			endcase
		end
	end

	// Access accepted on the second cycle of a request
	assign wr_lo = write && ack_r && byteenable[0];

	// Software writes zero to clear; bits above 4 are dropped
	always_comb begin
		sw_clear = '0;
		if (wr_lo && address == ccp_flags_pkg::flags_offset) begin
			sw_clear = ~writedata[4:0];
		end
		flags_nxt = (flags_r & ~sw_clear) | hardware_set;
	end

	// Next mask, so irq tracks a mask write in the same cycle as the flags
	always_comb begin
		mask_nxt = mask_r;
		if (wr_lo && address == ccp_flags_pkg::mask_offset) begin
			mask_nxt = writedata[4:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Flag register
	always_ff @(posedge clock) begin
		if (reset) begin
			flags_r <= ccp_flags_pkg::flags_reset;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// Mask and mode registers
	always_ff @(posedge clock) begin
		if (reset) begin
			mask_r <= ccp_flags_pkg::mask_reset;
			mode_r <= ccp_flags_pkg::mode_reset;
		end else begin
			mask_r <= mask_nxt;
			if (write && ack_r && address == ccp_flags_pkg::mode_offset) begin
				if (byteenable[0]) begin
					mode_r[7:0] <= writedata[7:0];
				end
				if (byteenable[1]) begin
					mode_r[9:8] <= writedata[9:8];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus handshake: one wait cycle, then accept
	always_ff @(posedge clock) begin
		if (reset) begin
			ack_r       <= 1'b0;
			waitrequest <= 1'b1;
		end else begin
			ack_r       <= (read || write) && !ack_r;
			waitrequest <= !((read || write) && !ack_r); // Idle high, low in the accept cycle
		end
	end

	// Read data registered in the wait cycle
	always_ff @(posedge clock) begin
		if (reset) begin
			readdata <= ccp_flags_pkg::unmapped_read;
		end else if (read && !ack_r) begin
			unique case (address)
				ccp_flags_pkg::flags_offset:    readdata <= {27'h0, flags_nxt};
				ccp_flags_pkg::mask_offset:     readdata <= {27'h0, mask_r};
				ccp_flags_pkg::irq_stat_offset: readdata <= {27'h0, flags_nxt & mask_r};
				ccp_flags_pkg::mode_offset:     readdata <= {22'h0, mode_r};
				default:                        readdata <= ccp_flags_pkg::unmapped_read;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs from flip-flops
	always_ff @(posedge clock) begin
		if (reset) begin
			ccp_event_flags <= ccp_flags_pkg::flags_reset;
			irq             <= 1'b0;
		end else begin
			ccp_event_flags <= flags_nxt;
			irq             <= |(flags_nxt & mask_nxt);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	property p_flag_position;
		@(posedge clock) disable iff (reset)
		(unit_mode(mode_r, 0) == ccp_flags_pkg::mode_capture && capture_event[0])
			|=> flags_r[0];
	endproperty
	a_flag_position: assert property (p_flag_position) else $error("unit1 not bit0");

	property p_upper_zero;
		@(posedge clock) disable iff (reset)
		(read && ack_r && address == ccp_flags_pkg::flags_offset) |-> readdata[31:5] == 27'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper bits nonzero");

	property p_capture_set;
		@(posedge clock) disable iff (reset)
		(unit_mode(mode_r, 2) == ccp_flags_pkg::mode_capture && capture_event[2])
			|=> flags_r[2] && ccp_event_flags[2];
	endproperty
	a_capture_set: assert property (p_capture_set) else $error("capture lost");

	property p_compare_set;
		@(posedge clock) disable iff (reset)
		(unit_mode(mode_r, 3) == ccp_flags_pkg::mode_compare && compare_event[3]) |=> flags_r[3];
	endproperty
	a_compare_set: assert property (p_compare_set) else $error("match lost");

	property p_pwm_set;
		@(posedge clock) disable iff (reset)
		(unit_mode(mode_r, 4) == ccp_flags_pkg::mode_pwm && pwm_trailing_edge[4]) |=> flags_r[4];
	endproperty
	a_pwm_set: assert property (p_pwm_set) else $error("edge lost");

	property p_no_self_clear;
		@(posedge clock) disable iff (reset)
		(($past(flags_r) & ~flags_r) != 5'h00)
			|-> $past(wr_lo && address == ccp_flags_pkg::flags_offset)
			&& (($past(flags_r) & ~flags_r & $past(writedata[4:0])) == 5'h00);
	endproperty
	a_no_self_clear: assert property (p_no_self_clear) else $error("flag self cleared");

	property p_reset_zero;
		@(posedge clock) $past(reset) |-> flags_r == 5'h00 && !irq;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("flags not reset");

	property p_set_wins;
		@(posedge clock) disable iff (reset)
		(hardware_set != 5'h00 && sw_clear != 5'h00) |=> (flags_r & $past(hardware_set))
			== $past(hardware_set);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat set");

	property p_irq_level;
		@(posedge clock) disable iff (reset)
		irq == |(flags_r & mask_r);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq missing");

	// Every request sees exactly one wait cycle
	property p_one_wait;
		@(posedge clock) disable iff (reset)
		((read || write) && waitrequest) |=> !waitrequest;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("no accept after wait");

	property p_accept_once;
		@(posedge clock) disable iff (reset)
		!waitrequest |=> waitrequest;
	endproperty
	a_accept_once: assert property (p_accept_once) else $error("accept held two cycles");

	c_capture: cover property (@(posedge clock) disable iff (reset) $rose(flags_r[0]));
	c_clear:   cover property (@(posedge clock) disable iff (reset) $fell(flags_r[4]));
	c_race:    cover property (@(posedge clock) disable iff (reset)
		(hardware_set & sw_clear) != 5'h00);
	c_irq:     cover property (@(posedge clock) disable iff (reset) $rose(irq));

endmodule : ccp_interrupt_flag_register

// *** verif/ccp_unit_model.sv ***
// Model of the five capture/compare/PWM units that emit event pulses
`timescale 1ns/10ps
module ccp_unit_model (
	// Event request, one bit per unit, and its kind
	input  wire logic [4:0] fire,
	input  wire logic [1:0] kind,
	// Pulses toward the flag block
	output logic      [4:0] capture_event,
	output logic      [4:0] compare_event,
	output logic      [4:0] pwm_trailing_edge
);
	// Route each request to the pulse of its kind only
	assign capture_event     = (kind == ccp_flags_pkg::mode_capture) ? fire : 5'h00;
	assign compare_event     = (kind == ccp_flags_pkg::mode_compare) ? fire : 5'h00;
	assign pwm_trailing_edge = (kind == ccp_flags_pkg::mode_pwm) ? fire : 5'h00;
endmodule : ccp_unit_model

// *** verif/ccp_interrupt_flag_register_tb.sv ***
// Testbench for the event flag block
`timescale 1ns/10ps
module ccp_interrupt_flag_register_tb;
	logic        clock, reset, read, write, waitrequest, irq;
	logic [3:0]  address, byteenable;
	logic [31:0] writedata, readdata, q, m, e;
	logic [4:0]  fire, cap, cmp, pwm, flags;
	logic [1:0]  kind;
	logic [1:0]  km [5] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h3};
	int          error_cnt = 0, check_count = 0, cyc = 0;
	////////////////////////////////////////////////////////////////
	// Design and unit model
	ccp_interrupt_flag_register DUT (.clock(clock), .reset(reset), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .capture_event(cap),
		.compare_event(cmp), .pwm_trailing_edge(pwm), .ccp_event_flags(flags), .irq(irq));
	ccp_unit_model units (.fire(fire), .kind(kind), .capture_event(cap),
		.compare_event(cmp), .pwm_trailing_edge(pwm));
	////////////////////////////////////////////////////////////////
	// Clock and timeout
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////
	// Bus, event and compare tasks
	task automatic results;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : results
	task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] g);
		check_count++;
		if (g !== ex) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, ex, g);
		end
	endtask : chk
	task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
		@(posedge clock);
		address   <= a;
		write     <= w;
		read      <= !w;
		writedata <= d;
		do @(posedge clock); while (waitrequest !== 1'b0);
		q = readdata;
		write <= 1'b0;
		read  <= 1'b0;
	endtask : bus
	task automatic rdchk(input string n, input logic [3:0] a, input logic [31:0] ex);
		bus(a, 1'b0, 32'h0);
		chk(n, ex, q);
	endtask : rdchk
	task automatic pulse(input logic [4:0] v, input logic [1:0] k);
		@(posedge clock);
		fire <= v;
		kind <= k;
		@(posedge clock);
		fire <= 5'h00;
		repeat (2) @(posedge clock);
	endtask : pulse
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		reset = 1'b1; read = 1'b0; write = 1'b0; address = 4'h0; writedata = 32'h0;
		byteenable = 4'hF; fire = 5'h00; kind = 2'h0; m = 32'h0; e = 32'h0;
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		rdchk("flags", 4'h0, 32'h0);
		rdchk("modes", 4'hC, 32'h0);
		pulse(5'h01, 2'h1);
		chk("flags off", 32'h0, {27'h0, flags});
		for (int i = 0; i < 5; i++) m = m | (32'(km[i]) << (2 * i));
		bus(4'hC, 1'b1, m);
		bus(4'h4, 1'b1, 32'h1F);
		pulse(5'h15, 2'h2);
		chk("wrong kind", 32'h0, {27'h0, flags});
		for (int i = 0; i < 5; i++) begin
			e = e | (32'h1 << i);
			pulse(5'(1 << i), km[i]);
			chk("flags", e, {27'h0, flags});
		end
		chk("irq", 32'h1, {31'h0, irq});
		rdchk("status", 4'h8, 32'h1F);
		bus(4'h0, 1'b1, 32'hFFFFFFFF);
		rdchk("flags", 4'h0, 32'h1F);
		fork
			bus(4'h0, 1'b1, 32'h0);
			begin
				repeat (2) @(posedge clock);
				fire <= 5'h04;
				kind <= 2'h1;
				@(posedge clock);
				fire <= 5'h00;
			end
		join
		rdchk("flags", 4'h0, 32'h04);
		bus(4'h4, 1'b1, 32'h0);
		repeat (2) @(posedge clock);
		chk("irq", 32'h0, {31'h0, irq});
		rdchk("status", 4'h8, 32'h0);
		rdchk("unmapped", 4'h2, 32'h0);
		bus(4'h0, 1'b1, 32'h0);
		rdchk("flags", 4'h0, 32'h0);
		bus(4'h4, 1'b1, 32'h1F);
		pulse(5'h10, 2'h3);
		chk("irq", 32'h1, {31'h0, irq});
		@(posedge clock);
		reset <= 1'b1;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		chk("flags rst", 32'h0, {27'h0, flags});
		chk("irq rst", 32'h0, {31'h0, irq});
		rdchk("mask rst", 4'h4, 32'h0);
		rdchk("modes rst", 4'hC, 32'h0);
		rdchk("flags rst", 4'h0, 32'h0);
		results();
	end
endmodule : ccp_interrupt_flag_register_tb
